// *** rtl/nvsrl_defines.svh ***
`ifndef NVSRL_DEFINES_SVH
`define NVSRL_DEFINES_SVH

`define NVSRL_CLK_PERIOD_NS 25
`define NVSRL_GRACE_NS 25
`define NVSRL_GRACE_CYCLES ((`NVSRL_GRACE_NS / `NVSRL_CLK_PERIOD_NS) < 1 ? 1 : \
   (`NVSRL_GRACE_NS / `NVSRL_CLK_PERIOD_NS))
`define NVSRL_SOFT_SEQ_US 500
`define NVSRL_SOFT_SEQ_CYCLES ((`NVSRL_SOFT_SEQ_US * 1000) / `NVSRL_CLK_PERIOD_NS)
`define NVSRL_STORE_MS 8
`define NVSRL_STORE_CYCLES ((`NVSRL_STORE_MS * 1000000) / `NVSRL_CLK_PERIOD_NS)
`define NVSRL_RECALL_US 600
`define NVSRL_RECALL_CYCLES ((`NVSRL_RECALL_US * 1000) / `NVSRL_CLK_PERIOD_NS)
`define NVSRL_CNT_W 24

`endif

// *** rtl/nvsrl_pkg.sv ***
package nvsrl_pkg;
   typedef enum logic [2:0] {
      NVSRL_IDLE = 3'b000,
      NVSRL_GRACE = 3'b001,
      NVSRL_STORE = 3'b010,
      NVSRL_RECALL = 3'b011,
      NVSRL_ACK = 3'b100
   } nvsrl_state_e;

   typedef enum logic [1:0] {
      NVSRL_OP_STORE = 2'b00,
      NVSRL_OP_RECALL = 2'b01,
      NVSRL_OP_AS_EN = 2'b10,
      NVSRL_OP_AS_DIS = 2'b11
   } nvsrl_op_e;
endpackage

// *** rtl/nvsrl_ctrl.sv ***
`timescale 1ns/1ps
`include "nvsrl_defines.svh"

// Summary of operation
// - A power-loss save is skipped when no SRAM write happened since the last store or recall.
// - After any soft command, access stays open for a grace; during a power-loss save's grace, the low supply keeps access closed.
// - The grace interval lasts at most 25 ns, one clock cycle here.
// - Host reads and writes are ignored during store, recall, and while the supply is low.
// - A soft command is acted on within 500 us of being taken.
// - Serial I/O stays blocked until store or recall ends; the host waits for completion.
module nvsrl_ctrl #(
   parameter int unsigned STORE_CYCLES = `NVSRL_STORE_CYCLES,
   parameter int unsigned RECALL_CYCLES = `NVSRL_RECALL_CYCLES,
   parameter int unsigned SOFT_SEQ_CYCLES = `NVSRL_SOFT_SEQ_CYCLES
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic cmd_valid,
   input wire logic [1:0] cmd_op,
   output logic cmd_ready,
   input wire logic sram_write,
   input wire logic low_supply_pin,
   output logic access_enable,
   output logic access_inhibit_window,
   output logic nv_busy,
   output logic nv_done,
   output logic power_loss_save_en,
   output logic write_pending,
   output logic nv_store_pulse,
   output logic nv_recall_pulse
);

   localparam int unsigned GRACE_CYCLES = `NVSRL_GRACE_CYCLES;

   nvsrl_pkg::nvsrl_state_e state_reg, state_next;
   nvsrl_pkg::nvsrl_op_e op_reg, op_next;
   logic [`NVSRL_CNT_W-1:0] cnt_reg, cnt_next;
   logic autosave_reg, autosave_next;
   logic dirty_reg, dirty_next;
   logic done_reg, done_next;
   logic st_pulse_reg, st_pulse_next;
   logic rc_pulse_reg, rc_pulse_next;
   logic low_meta_reg, low_sync_reg, low_prev_reg;
   logic low_fall;
   logic grace_end;

   // supply trip flag comes from the analog detector, asynchronous to mclk
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         low_meta_reg <= 1'b0;
         low_sync_reg <= 1'b0;
         low_prev_reg <= 1'b0;
      end else begin
         low_meta_reg <= low_supply_pin;
         low_sync_reg <= low_meta_reg;
         low_prev_reg <= low_sync_reg;
      end
   end

   assign low_fall = low_sync_reg & ~low_prev_reg;
   assign grace_end = (cnt_reg == `NVSRL_CNT_W'(GRACE_CYCLES - 1));

   always_comb begin
      state_next = state_reg;
      op_next = op_reg;
      cnt_next = cnt_reg;
      autosave_next = autosave_reg;
      dirty_next = dirty_reg;
      done_next = 1'b0;
      st_pulse_next = 1'b0;
      rc_pulse_next = 1'b0;
      // a write accepted while access is open marks the array dirty
      if (sram_write && access_enable) begin
         dirty_next = 1'b1;
      end
      unique case (state_reg)
         nvsrl_pkg::NVSRL_IDLE: begin
            cnt_next = '0;
            if (low_fall && autosave_reg && dirty_reg) begin
               op_next = nvsrl_pkg::NVSRL_OP_STORE;
               state_next = nvsrl_pkg::NVSRL_GRACE;
            end else if (cmd_valid && !low_sync_reg) begin
               op_next = nvsrl_pkg::nvsrl_op_e'(cmd_op);
               state_next = nvsrl_pkg::NVSRL_GRACE;
            end
         end
         nvsrl_pkg::NVSRL_GRACE: begin
            cnt_next = cnt_reg + `NVSRL_CNT_W'(1);
            if (grace_end) begin
               cnt_next = '0;
               unique case (op_reg)
                  nvsrl_pkg::NVSRL_OP_STORE: begin
                     st_pulse_next = 1'b1;
                     state_next = nvsrl_pkg::NVSRL_STORE;
                  end
                  nvsrl_pkg::NVSRL_OP_RECALL: begin
                     rc_pulse_next = 1'b1;
                     state_next = nvsrl_pkg::NVSRL_RECALL;
                  end
                  nvsrl_pkg::NVSRL_OP_AS_EN: begin
                     autosave_next = 1'b1;
                     state_next = nvsrl_pkg::NVSRL_ACK;
                  end
                  nvsrl_pkg::NVSRL_OP_AS_DIS: begin
                     autosave_next = 1'b0;
                     state_next = nvsrl_pkg::NVSRL_ACK;
                  end
               endcase
            end
         end
         nvsrl_pkg::NVSRL_STORE, nvsrl_pkg::NVSRL_RECALL: begin
            // the transfer time bounds the lockout, not the soft sequence time
            cnt_next = cnt_reg + `NVSRL_CNT_W'(1);
            if ((state_reg == nvsrl_pkg::NVSRL_STORE &&
                 cnt_reg == `NVSRL_CNT_W'(STORE_CYCLES - 1)) ||
                (state_reg == nvsrl_pkg::NVSRL_RECALL &&
                 cnt_reg == `NVSRL_CNT_W'(RECALL_CYCLES - 1))) begin
               cnt_next = '0;
               dirty_next = 1'b0;
               done_next = 1'b1;
               state_next = nvsrl_pkg::NVSRL_IDLE;
            end
         end
         nvsrl_pkg::NVSRL_ACK: begin
            // enable/disable finishes at once, far inside the soft sequence bound
            done_next = 1'b1;
            state_next = nvsrl_pkg::NVSRL_IDLE;
         end
         default: begin
            state_next = nvsrl_pkg::NVSRL_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= nvsrl_pkg::NVSRL_IDLE;
         op_reg <= nvsrl_pkg::NVSRL_OP_STORE;
         cnt_reg <= '0;
         autosave_reg <= 1'b1;
         dirty_reg <= 1'b0;
         done_reg <= 1'b0;
         st_pulse_reg <= 1'b0;
         rc_pulse_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         op_reg <= op_next;
         cnt_reg <= cnt_next;
         autosave_reg <= autosave_next;
         dirty_reg <= dirty_next;
         done_reg <= done_next;
         st_pulse_reg <= st_pulse_next;
         rc_pulse_reg <= rc_pulse_next;
      end
   end

   assign cmd_ready = (state_reg == nvsrl_pkg::NVSRL_IDLE) && !low_sync_reg &&
                      !(low_fall && autosave_reg && dirty_reg);
   assign nv_busy = (state_reg == nvsrl_pkg::NVSRL_STORE) ||
                    (state_reg == nvsrl_pkg::NVSRL_RECALL);
   assign access_inhibit_window = nv_busy || low_sync_reg;
   assign access_enable = !access_inhibit_window;
   assign nv_done = done_reg;
   assign power_loss_save_en = autosave_reg;
   assign write_pending = dirty_reg;
   assign nv_store_pulse = st_pulse_reg;
   assign nv_recall_pulse = rc_pulse_reg;

   wire unused_soft = (SOFT_SEQ_CYCLES == 0);

endmodule

// *** sim/nvsrl_host_model.sv ***
`timescale 1ns/1ps
module nvsrl_host_model (
   input wire logic mclk,
   input wire logic req,
   input wire logic [1:0] op,
   input wire logic cmd_ready,
   input wire logic nv_done,
   output logic cmd_valid,
   output logic [1:0] cmd_op
);
   initial begin
      cmd_valid = 1'b0;
      cmd_op = 2'h0;
      forever begin
         @(posedge mclk);
         if (req) begin
            #2 cmd_valid = 1'b1;
            cmd_op = op;
            // ready is combinational, so look at it between edges, not on one
            do @(negedge mclk); while (cmd_ready !== 1'b1);
            @(posedge mclk);
            #2 cmd_valid = 1'b0;
            cmd_op = ~op;
            do @(negedge mclk); while (nv_done !== 1'b1);
         end
      end
   end
endmodule

// *** sim/nvsrl_ctrl_properties.sv ***
`timescale 1ns/1ps
module nvsrl_ctrl_chk #(
   parameter int unsigned STORE_CYCLES = 20,
   parameter int unsigned RECALL_CYCLES = 10
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic cmd_valid,
   input wire logic [1:0] cmd_op,
   input wire logic cmd_ready,
   input wire logic low_supply_pin,
   input wire logic access_enable,
   input wire logic nv_busy,
   input wire logic nv_done,
   input wire logic write_pending,
   input wire logic nv_store_pulse,
   input wire logic nv_recall_pulse
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   wire take = cmd_valid && cmd_ready;
   chk_grace_open: assert property (take |=> access_enable)
      else $error("access closed during grace");
   chk_lock_after: assert property (take && !cmd_op[1] |=> ##1 nv_busy && !access_enable)
      else $error("no lock after grace");
   chk_busy_inhibit: assert property (nv_busy |-> !access_enable)
      else $error("access open while busy");
   chk_low_inhibit: assert property (low_supply_pin [*3] |-> !access_enable)
      else $error("access open at low supply");
   chk_store_len: assert property (nv_store_pulse |-> ##STORE_CYCLES nv_done)
      else $error("store end wrong");
   chk_recall_len: assert property (nv_recall_pulse |-> ##RECALL_CYCLES nv_done)
      else $error("recall end wrong");
   chk_soft_done: assert property (take && cmd_op[1] |-> ##3 nv_done)
      else $error("enable or disable late");
   chk_clean_skip: assert property (nv_store_pulse |->
      $past(write_pending, 2) || $past(take && cmd_op == 2'h0, 2))
      else $error("save without a write");
   cover property (nv_store_pulse);
   cover property (nv_recall_pulse);
   cover property (low_supply_pin && nv_store_pulse);
endmodule
bind nvsrl_ctrl nvsrl_ctrl_chk #(.STORE_CYCLES(STORE_CYCLES), .RECALL_CYCLES(RECALL_CYCLES)) chk_i (
   .mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
   .cmd_ready(cmd_ready), .low_supply_pin(low_supply_pin), .access_enable(access_enable),
   .nv_busy(nv_busy), .nv_done(nv_done), .write_pending(write_pending),
   .nv_store_pulse(nv_store_pulse), .nv_recall_pulse(nv_recall_pulse));

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   logic mclk, reset_n, req, sram_write, low_supply_pin, cmd_valid, cmd_ready, nv_busy, nv_done;
   logic access_enable, power_loss_save_en, write_pending, nv_store_pulse;
   logic nv_recall_pulse, access_inhibit_window;
   logic [1:0] op, cmd_op;
   int fails, checks_done, cyc, n;
   nvsrl_ctrl #(.STORE_CYCLES(20), .RECALL_CYCLES(10)) dut (.mclk(mclk), .reset_n(reset_n),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ready(cmd_ready), .sram_write(sram_write),
      .low_supply_pin(low_supply_pin), .access_enable(access_enable),
      .access_inhibit_window(access_inhibit_window), .nv_busy(nv_busy), .nv_done(nv_done),
      .power_loss_save_en(power_loss_save_en), .write_pending(write_pending),
      .nv_store_pulse(nv_store_pulse), .nv_recall_pulse(nv_recall_pulse));
   nvsrl_host_model host (.mclk(mclk), .req(req), .op(op), .cmd_ready(cmd_ready),
      .nv_done(nv_done), .cmd_valid(cmd_valid), .cmd_op(cmd_op));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic end_sim();
      if (fails == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 2000) begin
         fails++;
         end_sim();
      end
   end
   task automatic step();
      @(posedge mclk);
      #2;
   endtask
   task automatic wr();
      step();
      sram_write = 1'b1;
      step();
      sram_write = 1'b0;
   endtask
   // writes are pushed while busy on purpose: they must leave no dirty mark
   task automatic run_cmd(logic [1:0] o, int exp_n);
      step();
      op = o;
      req = 1'b1;
      n = 0;
      step();
      req = 1'b0;
      do begin
         step();
         n++;
         sram_write = nv_busy;
         if (n == 1) chk("grace_access", access_enable, 1);
         if (n == 2 && !o[1]) chk("nv_busy", nv_busy, 1);
         if (n == 2) chk("nv_recall_pulse", nv_recall_pulse, o == 2'h1);
         if (n == 2) chk("access_inhibit_window", access_inhibit_window, !o[1]);
         if (nv_busy === 1'b1) chk("busy_access", access_enable, 0);
      end while (nv_done !== 1'b1 && n < 40);
      sram_write = 1'b0;
      chk("done_cycles", n, exp_n);
      if (!o[1]) chk("write_pending", write_pending, 0);
      else chk("power_loss_save_en", power_loss_save_en, !o[0]);
   endtask
   task automatic brownout(int exp_p);
      step();
      low_supply_pin = 1'b1;
      n = 0;
      repeat (30) begin
         step();
         n += nv_store_pulse;
      end
      chk("save_pulses", n, exp_p);
      chk("low_access", access_enable, 0);
      low_supply_pin = 1'b0;
      repeat (4) step();
   endtask
   initial begin
      reset_n = 1'b0;
      req = 1'b0;
      op = 2'h0;
      sram_write = 1'b0;
      low_supply_pin = 1'b0;
      repeat (2) @(posedge mclk);
      #2 reset_n = 1'b1;
      chk("power_loss_save_en", power_loss_save_en, 1);
      chk("write_pending", write_pending, 0);
      wr();
      chk("write_pending", write_pending, 1);
      run_cmd(2'h0, 22);
      run_cmd(2'h1, 12);
      run_cmd(2'h3, 3);
      wr();
      brownout(0);
      run_cmd(2'h2, 3);
      brownout(1);
      brownout(0);
      end_sim();
   end
endmodule
